// ### pmpc_periph.sv
// model of the external parallel device that answers read strobes
`default_nettype none
module pmpc_periph (
  // clock
  input wire logic clk,
  // pads from the port and value to answer with
  input wire pmpc_pkg::pmpc_pads_s pads,
  input wire logic [15:0] rd_value,
  // data back to the port and what was seen
  output logic [15:0] data_in,
  output logic [15:0] addr_seen,
  output logic [15:0] mux_seen,
  output int strobe_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic on;
  logic was_on = 1'b0;
  logic [15:0] held = 16'h0000;
  logic [15:0] prev = 16'h0000;
  // strobe is taken as active high
  assign on = pads.rd_strobe_oe && pads.rd_strobe;
  // released bus shows the inverse, never a stale value
  assign data_in = on ? rd_value : ~held;
  initial begin
    addr_seen = 16'h0000;
    mux_seen = 16'h0000;
    strobe_count = 0;
  end
  // address phase is the cycle just before the strobe opens
  always @(posedge clk) begin
    prev <= pads.data_out & pads.data_oe;
    was_on <= on;
    if (on) begin
      held <= rd_value;
      addr_seen <= pads.addr_out & pads.addr_oe;
      strobe_count <= strobe_count + 1;
      if (!was_on) mux_seen <= prev;
    end
  end
endmodule : pmpc_periph
`default_nettype wire

// ### pmpc_pkg.sv
// package for the parallel master port control block
`default_nettype none
package pmpc_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PIN_EN_OFFSET = 8'h04;
  localparam logic [7:0] RADDR_OFFSET = 8'h08;
  localparam logic [7:0] WADDR_OFFSET = 8'h0C;
  localparam logic [7:0] DIN_OFFSET = 8'h10;
  localparam logic [7:0] DOUT_OFFSET = 8'h14;
  // control field positions
  localparam int READ_START_BIT = 23;
  localparam int SPLIT_BUF_BIT = 17;
  localparam int PORT_ON_BIT = 15;
  localparam int STOP_IDLE_BIT = 13;
  localparam int MUX_LSB = 11;
  localparam int TTL_BIT = 10;
  localparam int WR_EN_BIT = 9;
  localparam int RD_EN_BIT = 8;
  localparam int CSF_LSB = 6;
  localparam int ALP_BIT = 5;
  localparam int CHIP_SELECT_TWO_POLARITY_BIT = 4;
  localparam int CHIP_SELECT_ONE_POLARITY_BIT = 3;
  localparam int WRITE_STROBE_POLARITY_BIT = 1;
  localparam int READ_STROBE_POLARITY_BIT = 0;
  // writable bits of the control register; the rest read zero
  localparam logic [31:0] CTRL_MASK = 32'h0082_BFFB;
  localparam logic [31:0] PIN_EN_MASK = 32'h0000_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] PIN_EN_RESET = 16'h0000;
  // address/data multiplexing modes
  localparam logic [1:0] MUX_SEPARATE = 2'h0;
  localparam logic [1:0] MUX_LOW8 = 2'h1;
  localparam logic [1:0] MUX_FULL16 = 2'h2;
  localparam logic [1:0] MUX_LOW8_WIDE = 2'h3;
  // chip-select function value that keeps the top pads as address lines
  localparam logic [1:0] CSF_ADDR = 2'h0;
  // read cycle phase lengths in clock cycles
  localparam int unsigned READ_SETUP_CYCLES = 2;
  localparam int unsigned READ_STROBE_CYCLES = 4;
  // read cycle states
  typedef enum logic [2:0] {
    PMPC_IDLE = 3'b001,
    PMPC_SETUP = 3'b010,
    PMPC_STROBE = 3'b100
  } pmpc_state_e;
  // pad group carried to the pin layer
  typedef struct packed {
    logic [15:0] addr_out;
    logic [15:0] addr_oe;
    logic [15:0] data_out;
    logic [15:0] data_oe;
    logic cs1;
    logic cs2;
    logic latch_high;
    logic latch_low;
    logic rd_strobe;
    logic wr_strobe;
    logic rd_strobe_oe;
    logic wr_strobe_oe;
  } pmpc_pads_s;
endpackage : pmpc_pkg
`default_nettype wire

// ### pmpc_top.sv
// parallel master port control, pin enables and read cycle engine
//
// Our own choices: the register addresses and the strobed register port.
`default_nettype none
// Summary of operation
// - setting read start runs one bus read, hardware clears the bit after; zero ignored
// - split buffer selects separate read/write address registers; data registers are the same in both modes
// - port enable clear means no off-chip bus access at all
// - stop-in-idle halts the port while the device is idle
// - mux field places address on separate pins, data low byte or data word
// - write strobe pin driven only when its pin enable is set
// - read strobe pin driven only when its pin enable is set
// - select and polarity bits ignored where pins serve as address lines
// - top pin enables hand pads 15:14 to the port, else general I/O
// - middle pin enables make pads 13:2 port address outputs
// - lowest pin enables hand pads 1:0 to the port, else general I/O
// - top pads choose address or chip select by chip-select function
// - lowest pads choose address or latch strobe by the mux mode
// - unimplemented bits read zero, all control bits reset to zero
module pmpc_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // device power state
  input wire logic device_idle,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // external data pins
  input wire logic [15:0] port_data_pins_in,
  output pmpc_pkg::pmpc_pads_s pads,
  output logic input_buffer_type_select
);

  logic [31:0] ctrl;
  logic [15:0] pin_en;
  logic [15:0] raddr;
  logic [15:0] waddr;
  logic [15:0] din;
  logic [15:0] dout;
  logic [15:0] data_sync1;
  logic [15:0] data_sync2;
  logic [2:0] phase_cnt;
  pmpc_pkg::pmpc_state_e state;
  pmpc_pkg::pmpc_state_e next_state;
  logic running;
  logic read_done;
  logic wr_ctrl;
  logic [1:0] mux_mode;
  logic [1:0] csf;
  logic [15:0] cur_addr;

  // bus access only while enabled and not halted by idle
  assign running = ctrl[pmpc_pkg::PORT_ON_BIT] &&
                   !(ctrl[pmpc_pkg::STOP_IDLE_BIT] && device_idle);
  assign mux_mode = ctrl[pmpc_pkg::MUX_LSB +: 2];
  assign csf = ctrl[pmpc_pkg::CSF_LSB +: 2];
  assign wr_ctrl = reg_write && (reg_addr == pmpc_pkg::CTRL_OFFSET);
  assign input_buffer_type_select = ctrl[pmpc_pkg::TTL_BIT];
  // shared mode reads through the write address register
  assign cur_addr = ctrl[pmpc_pkg::SPLIT_BUF_BIT] ? raddr : waddr;

  // data pins are asynchronous to clk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_sync1 <= 16'h0000;
      data_sync2 <= 16'h0000;
    end else begin
      data_sync1 <= port_data_pins_in;
      data_sync2 <= data_sync1;
    end
  end

  // read cycle state machine
  always_comb begin
    next_state = state;
    case (state)
      pmpc_pkg::PMPC_IDLE: begin
        if (ctrl[pmpc_pkg::READ_START_BIT] && running) begin
          next_state = pmpc_pkg::PMPC_SETUP;
        end
      end
      pmpc_pkg::PMPC_SETUP: begin
        if (phase_cnt == 3'(pmpc_pkg::READ_SETUP_CYCLES - 1)) begin
          next_state = pmpc_pkg::PMPC_STROBE;
        end
      end
      pmpc_pkg::PMPC_STROBE: begin
        if (phase_cnt == 3'(pmpc_pkg::READ_STROBE_CYCLES - 1)) begin
          next_state = pmpc_pkg::PMPC_IDLE;
        end
      end
      default: begin
        next_state = pmpc_pkg::PMPC_IDLE;
      end
    endcase
    // a disabled port abandons the cycle at once
    if (!running) begin
      next_state = pmpc_pkg::PMPC_IDLE;
    end
  end

  assign read_done = (state == pmpc_pkg::PMPC_STROBE) &&
                     (next_state == pmpc_pkg::PMPC_IDLE);

  // state and phase counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= pmpc_pkg::PMPC_IDLE;
      phase_cnt <= 3'h0;
    end else begin
      state <= next_state;
      phase_cnt <= (next_state != state) ? 3'h0 : phase_cnt + 3'h1;
    end
  end

  // control register; hardware clear of read start beats a software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= pmpc_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        // writing zero to read start never cancels a pending read
        ctrl <= (reg_wdata & pmpc_pkg::CTRL_MASK) |
                (ctrl & (32'h1 << pmpc_pkg::READ_START_BIT));
      end
      if (read_done || (state != pmpc_pkg::PMPC_IDLE && !running)) begin
        ctrl[pmpc_pkg::READ_START_BIT] <= 1'b0;
      end
    end
  end

  // pin enable and buffer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_en <= pmpc_pkg::PIN_EN_RESET;
      raddr <= 16'h0000;
      waddr <= 16'h0000;
      dout <= 16'h0000;
    end else if (reg_write) begin
      if (reg_addr == pmpc_pkg::PIN_EN_OFFSET) begin
        pin_en <= reg_wdata[15:0];
      end else if (reg_addr == pmpc_pkg::RADDR_OFFSET) begin
        raddr <= reg_wdata[15:0];
      end else if (reg_addr == pmpc_pkg::WADDR_OFFSET) begin
        waddr <= reg_wdata[15:0];
      end else if (reg_addr == pmpc_pkg::DOUT_OFFSET) begin
        dout <= reg_wdata[15:0];
      end
    end
  end

  // captured read data, taken at the end of the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din <= 16'h0000;
    end else if (read_done) begin
      din <= data_sync2;
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      if (reg_addr == pmpc_pkg::CTRL_OFFSET) begin
        reg_rdata <= ctrl & pmpc_pkg::CTRL_MASK;
      end else if (reg_addr == pmpc_pkg::PIN_EN_OFFSET) begin
        reg_rdata <= {16'h0000, pin_en};
      end else if (reg_addr == pmpc_pkg::RADDR_OFFSET) begin
        reg_rdata <= {16'h0000, raddr};
      end else if (reg_addr == pmpc_pkg::WADDR_OFFSET) begin
        reg_rdata <= {16'h0000, waddr};
      end else if (reg_addr == pmpc_pkg::DIN_OFFSET) begin
        // shared data register reads the last captured word in both modes
        reg_rdata <= {16'h0000, din};
      end else if (reg_addr == pmpc_pkg::DOUT_OFFSET) begin
        reg_rdata <= {16'h0000, dout};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // pad drive: registered so pins never glitch
  always_ff @(posedge clk or negedge reset_n) begin
    logic [15:0] addr_drv;
    logic setup_ph;
    logic strobe_ph;
    logic top_cs;
    logic low_latch;
    addr_drv = 16'h0000;
    setup_ph = 1'b0;
    strobe_ph = 1'b0;
    top_cs = 1'b0;
    low_latch = 1'b0;
    if (!reset_n) begin
      pads <= '0;
    end else begin
      setup_ph = (state == pmpc_pkg::PMPC_SETUP);
      strobe_ph = (state == pmpc_pkg::PMPC_STROBE);
      top_cs = (csf != pmpc_pkg::CSF_ADDR);
      low_latch = (mux_mode != pmpc_pkg::MUX_SEPARATE);
      addr_drv = cur_addr;
      // high byte on address pins only in the separate and MUX_LOW8 modes
      if (mux_mode == pmpc_pkg::MUX_FULL16 || mux_mode == pmpc_pkg::MUX_LOW8_WIDE) begin
        addr_drv[15:8] = 8'h00;
      end
      pads.addr_out <= addr_drv;
      pads.addr_oe[13:2] <= pin_en[13:2];
      pads.addr_oe[15:14] <= pin_en[15:14] & {2{!top_cs}};
      pads.addr_oe[1:0] <= pin_en[1:0] & {2{!low_latch}};
      // address phase on the data lines for multiplexed modes
      pads.data_oe <= 16'h0000;
      pads.data_out <= 16'h0000;
      if (setup_ph && low_latch) begin
        case (mux_mode)
          pmpc_pkg::MUX_LOW8: begin
            pads.data_out <= {8'h00, cur_addr[7:0]};
            pads.data_oe <= 16'h00FF;
          end
          pmpc_pkg::MUX_FULL16: begin
            pads.data_out <= cur_addr;
            pads.data_oe <= 16'hFFFF;
          end
          default: begin
            pads.data_out <= {8'h00, cur_addr[7:0]};
            pads.data_oe <= 16'hFFFF;
          end
        endcase
      end
      // polarity and select only act where the pad is not an address line
      pads.cs1 <= pin_en[15] && top_cs && ((setup_ph || strobe_ph) ^
                  !ctrl[pmpc_pkg::CHIP_SELECT_ONE_POLARITY_BIT]);
      pads.cs2 <= pin_en[14] && top_cs && ((setup_ph || strobe_ph) ^
                  !ctrl[pmpc_pkg::CHIP_SELECT_TWO_POLARITY_BIT]);
      pads.latch_high <= pin_en[1] && low_latch &&
                         (setup_ph ^ !ctrl[pmpc_pkg::ALP_BIT]);
      pads.latch_low <= pin_en[0] && low_latch &&
                        (setup_ph ^ !ctrl[pmpc_pkg::ALP_BIT]);
      pads.rd_strobe <= strobe_ph ^ !ctrl[pmpc_pkg::READ_STROBE_POLARITY_BIT];
      pads.wr_strobe <= !ctrl[pmpc_pkg::WRITE_STROBE_POLARITY_BIT];
      pads.rd_strobe_oe <= ctrl[pmpc_pkg::RD_EN_BIT] && running;
      pads.wr_strobe_oe <= ctrl[pmpc_pkg::WR_EN_BIT] && running;
    end
  end

  // read start clears within a full read cycle
  property p_read_clears;
    @(posedge clk) disable iff (!reset_n)
    ($rose(state == pmpc_pkg::PMPC_SETUP)) |->
      ##[1:8] !ctrl[pmpc_pkg::READ_START_BIT];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read start not cleared");

  // setup lasts the documented cycles then strobes
  property p_setup_len;
    @(posedge clk) disable iff (!reset_n)
    ($rose(state == pmpc_pkg::PMPC_SETUP) && running) ##1 running[*1] |=>
      (state == pmpc_pkg::PMPC_STROBE);
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup phase length wrong");

  // disabled port never cycles
  property p_off_no_access;
    @(posedge clk) disable iff (!reset_n)
    !running |=> (state == pmpc_pkg::PMPC_IDLE);
  endproperty
  a_off_no_access: assert property (p_off_no_access) else $error("access while off");

  // strobe enables stay off while their control bits are clear
  property p_wr_oe;
    @(posedge clk) disable iff (!reset_n)
    !ctrl[pmpc_pkg::WR_EN_BIT] |=> !pads.wr_strobe_oe;
  endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write strobe driven while off");

  property p_rd_oe;
    @(posedge clk) disable iff (!reset_n)
    !ctrl[pmpc_pkg::RD_EN_BIT] |=> !pads.rd_strobe_oe;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read strobe driven while off");

  // middle pads follow pin enables
  property p_mid_pads;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> pads.addr_oe[13:2] == $past(pin_en[13:2]);
  endproperty
  a_mid_pads: assert property (p_mid_pads) else $error("address pad enable wrong");

  // top pads never both address and chip select
  property p_top_excl;
    @(posedge clk) disable iff (!reset_n)
    (csf != pmpc_pkg::CSF_ADDR) |=> pads.addr_oe[15:14] == 2'h0;
  endproperty
  a_top_excl: assert property (p_top_excl) else $error("top pad double use");

  // unimplemented control bits read zero
  property p_ctrl_zero;
    @(posedge clk) disable iff (!reset_n)
    (ctrl & ~pmpc_pkg::CTRL_MASK) == 32'h0000_0000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("reserved bit set");

  // chip selects stay quiet while the top pads are address lines
  property p_cs_quiet;
    @(posedge clk) disable iff (!reset_n)
    (csf == pmpc_pkg::CSF_ADDR) |=> !pads.cs1 && !pads.cs2;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("chip select on address pad");

  // latch strobes stay quiet when address has its own pins
  property p_latch_quiet;
    @(posedge clk) disable iff (!reset_n)
    (mux_mode == pmpc_pkg::MUX_SEPARATE) |=> !pads.latch_high && !pads.latch_low;
  endproperty
  a_latch_quiet: assert property (p_latch_quiet) else $error("latch on address pad");

  // low pads give way to the latch strobes in multiplexed modes
  property p_low_pads;
    @(posedge clk) disable iff (!reset_n)
    (mux_mode != pmpc_pkg::MUX_SEPARATE) |=> pads.addr_oe[1:0] == 2'h0;
  endproperty
  a_low_pads: assert property (p_low_pads) else $error("low pad double use");

  // halted in idle means no cycle runs
  property p_idle_halt;
    @(posedge clk) disable iff (!reset_n)
    (ctrl[pmpc_pkg::STOP_IDLE_BIT] && device_idle) |=> state == pmpc_pkg::PMPC_IDLE;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("cycle while idle halted");

  // full word multiplexing leaves the high address pins low
  property p_full16_high;
    @(posedge clk) disable iff (!reset_n)
    (mux_mode == pmpc_pkg::MUX_FULL16) |=> pads.addr_out[15:8] == 8'h00;
  endproperty
  a_full16_high: assert property (p_full16_high) else $error("high address pins driven");

endmodule : pmpc_top
`default_nettype wire

// ### tb_top.sv
// self-checking testbench for the parallel master port control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic device_idle = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] port_data_pins_in;
  pmpc_pkg::pmpc_pads_s pads;
  logic input_buffer_type_select;
  logic [15:0] rd_value = 16'h0000;
  logic [15:0] addr_seen;
  logic [15:0] mux_seen;
  int strobe_count;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 74453;
  // read start, port on, read strobe active high
  localparam logic [31:0] GO = 32'h0080_8001;
  pmpc_top uut (.clk(clk), .reset_n(reset_n), .device_idle(device_idle),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .port_data_pins_in(port_data_pins_in),
    .pads(pads), .input_buffer_type_select(input_buffer_type_select));
  pmpc_periph peer (.clk(clk), .pads(pads), .rd_value(rd_value),
    .data_in(port_data_pins_in), .addr_seen(addr_seen), .mux_seen(mux_seen),
    .strobe_count(strobe_count));
  always #2 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // bounded poll for the self-clearing start bit
  task automatic wait_clear();
    logic [31:0] d;
    d = 32'hFFFF_FFFF;
    for (int i = 0; i < 40 && d[23] !== 1'b0; i++) rd(pmpc_pkg::CTRL_OFFSET, d);
    chk({31'h0, d[23]}, 32'h0);
  endtask : wait_clear
  task automatic run(input logic [31:0] c, input int n);
    int n0;
    n0 = strobe_count;
    wr(pmpc_pkg::CTRL_OFFSET, c);
    wait_clear();
    chk(32'(strobe_count - n0), 32'(n));
  endtask : run
  // masked data pins during the address phase
  function automatic logic [15:0] exp_mux(input logic [1:0] m, input logic [15:0] a);
    if (m == pmpc_pkg::MUX_SEPARATE) return 16'h0000;
    if (m == pmpc_pkg::MUX_FULL16) return a;
    return {8'h00, a[7:0]};
  endfunction : exp_mux
  // pads handed to the port as address lines
  function automatic logic [15:0] exp_oe(input logic [15:0] pe, input logic [1:0] cf,
      input logic [1:0] m);
    logic [15:0] r;
    r = pe;
    if (cf != pmpc_pkg::CSF_ADDR) r[15:14] = 2'h0;
    if (m != pmpc_pkg::MUX_SEPARATE) r[1:0] = 2'h0;
    return r;
  endfunction : exp_oe
  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] v;
    logic [15:0] pe;
    logic [15:0] a;
    logic [1:0] m;
    logic [1:0] cf;
    logic s;
    int n0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(pmpc_pkg::CTRL_OFFSET, d);
    chk(d, pmpc_pkg::CTRL_RESET);
    rd(pmpc_pkg::PIN_EN_OFFSET, d);
    chk(d, {16'h0000, pmpc_pkg::PIN_EN_RESET});
    rd(8'hFC, d);
    chk(d, 32'h0);
    $display("test reset done");
    // random settings, no read start, strobe level kept high
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      v[23] = 1'b0;
      v[0] = 1'b1;
      wr(pmpc_pkg::CTRL_OFFSET, v);
      rd(pmpc_pkg::CTRL_OFFSET, d);
      chk(d, v & pmpc_pkg::CTRL_MASK);
      chk({31'h0, pads.wr_strobe_oe}, {31'h0, v[15] & v[9]});
      chk({31'h0, pads.rd_strobe_oe}, {31'h0, v[15] & v[8]});
      chk({31'h0, input_buffer_type_select}, {31'h0, v[10]});
      v = $random(seed);
      wr(pmpc_pkg::PIN_EN_OFFSET, v);
      rd(pmpc_pkg::PIN_EN_OFFSET, d);
      chk(d, v & pmpc_pkg::PIN_EN_MASK);
    end
    $display("test settings done");
    // every mux mode, shared and split buffers
    for (int k = 0; k < 5; k++) begin
      m = (k == 4) ? 2'h0 : 2'(k);
      s = (k >= 2);
      cf = 2'($random(seed));
      pe = 16'($random(seed));
      a = 16'($random(seed));
      rd_value <= 16'($random(seed));
      wr(pmpc_pkg::PIN_EN_OFFSET, {16'h0, pe});
      wr(pmpc_pkg::RADDR_OFFSET, {16'h0, a});
      wr(pmpc_pkg::WADDR_OFFSET, {16'h0, ~a});
      wr(pmpc_pkg::DOUT_OFFSET, {16'h0, pe});
      rd(pmpc_pkg::RADDR_OFFSET, d);
      chk(d, {16'h0, a});
      rd(pmpc_pkg::WADDR_OFFSET, d);
      chk(d, {16'h0, ~a});
      rd(pmpc_pkg::DOUT_OFFSET, d);
      chk(d, {16'h0, pe});
      if (!s) a = ~a;
      v = GO | ({31'h0, s} << 17) | ({30'h0, m} << 11) | ({30'h0, cf} << 6) | 32'h100;
      run(v, 4);
      chk({16'h0, pads.addr_oe}, {16'h0, exp_oe(pe, cf, m)});
      if (m == 2'h0) chk({16'h0, addr_seen}, {16'h0, a & exp_oe(pe, cf, m)});
      chk({16'h0, mux_seen}, {16'h0, exp_mux(m, a)});
      rd(pmpc_pkg::DIN_OFFSET, d);
      chk(d, {16'h0, rd_value});
    end
    $display("test read cycles done");
    // start while off stays pending, enabling runs it
    n0 = strobe_count;
    wr(pmpc_pkg::CTRL_OFFSET, 32'h0080_0101);
    repeat (20) @(posedge clk);
    chk(32'(strobe_count - n0), 32'h0);
    run(32'h0000_8101, 4);
    // halted in idle until idle ends
    device_idle <= 1'b1;
    wr(pmpc_pkg::CTRL_OFFSET, GO | 32'h2100);
    repeat (20) @(posedge clk);
    chk(32'(strobe_count - n0), 32'h4);
    device_idle <= 1'b0;
    wait_clear();
    chk(32'(strobe_count - n0), 32'h8);
    device_idle <= 1'b1;
    run(GO | 32'h100, 4);
    device_idle <= 1'b0;
    // read strobe pin disabled: cycle ends, no strobe seen
    run(GO, 0);
    $display("test enables done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
